// ### core/exception_report_standby_ctl.sv
// Purpose: port, power and exception page state; standby and report scheduling
// Assumes: command decode outside; events and pins already in clock domain
// Notes: register port answers reads one cycle later
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "exc_defines.svh"
module exception_report_standby_ctl #(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic page_reject,
  input wire logic temp_over,
  input wire logic fail_predict,
  input wire logic per_bit,
  input wire logic cmd_start,
  input wire logic cmd_done,
  input wire logic cmd_media,
  input wire logic req_sense,
  output logic cmd_block,
  output logic report_valid,
  output logic [3:0] sense_key,
  output logic [7:0] sense_asc,
  output logic [7:0] sense_ascq,
  output logic standby,
  output logic background_on,
  output logic log_save_enable
);
  initial
  begin
    if (TICK_CYCLES < 2)
      $error("tick period below two cycles");
  end
  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic standby_en_r;
  logic [31:0] standby_tmr_r;
  logic [31:0] exc_ctl_r;
  logic [31:0] interval_r;
  logic [31:0] report_cnt_r;
  logic [31:0] rdata_r;
  logic reject_r;

  wire wr_port = wr && addr == `ADDR_PORT_CTL;
  wire wr_pow = wr && addr == `ADDR_POWER_CTL;
  wire wr_sby = wr && addr == `ADDR_STANDBY_TMR;
  wire wr_exc = wr && addr == `ADDR_EXC_CTL;
  wire wr_int = wr && addr == `ADDR_INTERVAL;
  wire wr_cnt = wr && addr == `ADDR_REPORT_CNT;
  wire [3:0] new_method = wdata[`FLD_METHOD_LSB +: 4];
  wire method_bad = new_method > 4'(exc_pkg::M_ON_REQUEST); // see RULE23
  // performance and error-logging bits kept for read-back only
  wire [31:0] exc_keep = {20'h0_0000, new_method, wdata[7:0]} &
    32'h0000_0fbd; // see RULE13

  wire exc_dis = exc_ctl_r[`BIT_EXC_DIS];
  wire warn_en = exc_ctl_r[`BIT_WARN_EN];
  wire test_on = exc_ctl_r[`BIT_TEST];
  wire [3:0] method = exc_ctl_r[`FLD_METHOD_LSB +: 4];
  wire method_used = !(exc_dis && !warn_en); // see RULE10

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      standby_en_r <= 1'b0;
      standby_tmr_r <= 32'h0000_0000;
      exc_ctl_r <= `EXC_CTL_RESET;
      interval_r <= 32'h0000_0000;
      report_cnt_r <= 32'h0000_0000;
    end
    else
    begin
      if (wr_pow)
        standby_en_r <= wdata[`BIT_STANDBY]; // see RULE4
      if (wr_sby)
        standby_tmr_r <= wdata;
      if (wr_exc && !method_bad)
        exc_ctl_r <= exc_keep;
      if (wr_int)
        interval_r <= wdata;
      if (wr_cnt)
        report_cnt_r <= wdata;
    end
  end

  // page writes with nonzero must-be-zero fields raise page_reject; a power write still loads its standby bit
  wire bad_port = wr_port && wdata[31:16] != 16'h0000; // see RULE2
  wire bad_pow = wr_pow && wdata[`BIT_IDLE]; // see RULE3
  wire bad_exc = wr_exc && method_bad; // see RULE23

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      reject_r <= 1'b0;
    else
      reject_r <= bad_port || bad_pow || bad_exc;
  end
  assign page_reject = reject_r;

  // ------------------------------------------------------------
  // timers
  // ------------------------------------------------------------
  logic tick;
  tick_gen #(.CYCLES(TICK_CYCLES)) u_tick (
    .clock(clock),
    .rst_n(rst_n),
    .tick(tick)
  );

  logic standby_r;
  logic sby_expired;
  wire sby_load = cmd_start || wr_sby || wr_pow; // see RULE24
  tick_timer #(.W(32)) u_sby (
    .clock(clock),
    .rst_n(rst_n),
    .tick(tick),
    .load(sby_load),
    .value(wr_sby ? wdata : standby_tmr_r),
    .expired(sby_expired)
  );
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      standby_r <= 1'b0;
    else if (!standby_en_r || (cmd_start && cmd_media))
      standby_r <= 1'b0; // see RULE4
    else if (sby_expired && !sby_load && tick)
      standby_r <= 1'b1; // see RULE5
  end
  assign standby = standby_r;

  // ------------------------------------------------------------
  // exception conditions
  // ------------------------------------------------------------
  logic pend_r;
  logic [7:0] asc_r;
  logic [7:0] ascq_r;
  logic [31:0] sent_r;
  logic once_done_r;
  logic int_expired;
  logic report_fire;
  wire exc_on = !exc_dis; // see RULE9
  wire temp_ev = temp_over && warn_en && exc_on; // see RULE6
  wire fail_ev = fail_predict && exc_on;
  wire test_ev = test_on && exc_on; // see RULE11
  wire any_ev = temp_ev || fail_ev || test_ev;
  wire cnt_left = report_cnt_r == 32'h0000_0000 || sent_r < report_cnt_r; // see RULE22
  wire once_ok = interval_r != 32'h0000_0000 || !once_done_r; // see RULE21
  wire may_report = pend_r && int_expired && cnt_left && once_ok && method_used &&
    exc_on;

  tick_timer #(.W(32)) u_int (
    .clock(clock),
    .rst_n(rst_n),
    .tick(tick),
    .load(report_fire),
    .value(interval_r),
    .expired(int_expired)
  ); // see RULE20

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pend_r <= 1'b0;
      asc_r <= 8'h00;
      ascq_r <= 8'h00;
    end
    else if (any_ev)
    begin
      pend_r <= 1'b1; // new event wins over a clear in the same cycle
      asc_r <= temp_ev ? `ASC_TEMP : `ASC_FAIL; // see RULE7
      ascq_r <= temp_ev ? `ASCQ_TEMP : (test_ev ? `ASCQ_TEST : 8'h00);
    end
    // level test: a clear written while the test event still stands is not lost
    else if (!exc_on || (ascq_r == `ASCQ_TEST && !test_on))
      pend_r <= 1'b0; // see RULE8, RULE11
  end

  // ------------------------------------------------------------
  // delivery per method
  // ------------------------------------------------------------
  wire m_ua = method == 4'(exc_pkg::M_UNIT_ATTN);
  wire m_cr = method == 4'(exc_pkg::M_COND_REC) && per_bit; // see RULE16
  wire m_ur = method == 4'(exc_pkg::M_UNCOND_REC); // see RULE17
  wire m_ns = method == 4'(exc_pkg::M_NO_SENSE); // see RULE18
  wire m_rq = method == 4'(exc_pkg::M_ON_REQUEST); // see RULE19
  // methods zero and one never deliver, see RULE14
  wire deliver_ua = may_report && m_ua && cmd_start; // see RULE15
  wire deliver_after = may_report && (m_cr || m_ur || m_ns) && cmd_done;
  wire deliver_req = may_report && m_rq && req_sense;
  assign report_fire = deliver_ua || deliver_after || deliver_req;
  wire [3:0] key_sel = m_ua ? `KEY_UNIT_ATTN :
    ((m_cr || m_ur) ? `KEY_RECOVERED : `KEY_NO_SENSE);

  logic valid_r;
  logic [3:0] key_r;
  logic [7:0] asc_o_r;
  logic [7:0] ascq_o_r;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      valid_r <= 1'b0;
      key_r <= 4'h0;
      asc_o_r <= 8'h00;
      ascq_o_r <= 8'h00;
      sent_r <= 32'h0000_0000;
      once_done_r <= 1'b0;
    end
    else
    begin
      valid_r <= report_fire;
      if (report_fire)
      begin
        key_r <= key_sel;
        asc_o_r <= asc_r;
        ascq_o_r <= ascq_r;
        sent_r <= sent_r + 32'h0000_0001;
        once_done_r <= 1'b1;
      end
      else if (wr_exc || wr_int || wr_cnt)
      begin
        sent_r <= 32'h0000_0000;
        once_done_r <= 1'b0;
      end
    end
  end
  assign report_valid = valid_r;
  assign sense_key = key_r;
  assign sense_asc = asc_o_r;
  assign sense_ascq = ascq_o_r;
  assign cmd_block = deliver_ua; // see RULE15
  assign background_on = exc_ctl_r[`BIT_BG_EN]; // see RULE12
  assign log_save_enable = exc_on; // see RULE8

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  wire [31:0] status_w = {28'h000_0000, once_done_r, pend_r, 1'b0, standby_r};
  wire [31:0] sel_w =
    addr == `ADDR_PORT_CTL ? {28'h000_0000, `PROTOCOL_ID} : // see RULE1
    addr == `ADDR_POWER_CTL ? {31'h0000_0000, standby_en_r} :
    addr == `ADDR_STANDBY_TMR ? standby_tmr_r :
    addr == `ADDR_EXC_CTL ? exc_ctl_r :
    addr == `ADDR_INTERVAL ? interval_r :
    addr == `ADDR_REPORT_CNT ? report_cnt_r :
    addr == `ADDR_STATUS ? status_w :
    addr == `ADDR_SENSE ? {12'h000, key_r, asc_o_r, ascq_o_r} : 32'h0000_0000;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rdata_r <= 32'h0000_0000;
    else
      rdata_r <= rd ? sel_w : 32'h0000_0000;
  end
  assign rdata = rdata_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  port_id_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE1
    rd && addr == `ADDR_PORT_CTL |=> rdata == 32'h0000_0001)
    else $error("protocol identifier not one");
  no_standby_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE4
    !standby_en_r |=> !standby_r)
    else $error("standby while disabled");
  silent_dis_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE8
    exc_dis && !warn_en |-> !report_fire)
    else $error("report while exceptions disabled");
  method_zero_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE14
    method < 4'h2 |-> !report_fire)
    else $error("report under silent method");
  ua_key_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE15
    deliver_ua |=> report_valid && sense_key == `KEY_UNIT_ATTN)
    else $error("unit attention key wrong");
  req_only_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE19
    report_fire && m_rq |-> req_sense)
    else $error("on-request report without poll");
  spacing_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE20
    report_fire && interval_r != 32'h0000_0000 |=> !report_fire)
    else $error("reports not spaced");
  count_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE22
    report_cnt_r != 32'h0000_0000 && sent_r >= report_cnt_r |-> !report_fire)
    else $error("report count exceeded");
  bad_method_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE23
    wr_exc && method_bad |=> page_reject && $stable(exc_ctl_r))
    else $error("reserved method accepted");

  // ------------------------------------------------------------
  // multi-step and same-cycle checks
  // ------------------------------------------------------------
  sequence media_cmd_s;
    cmd_start && cmd_media;
  endsequence
  sequence test_dropped_s;
    ascq_r == `ASCQ_TEST && !test_on && !any_ev;
  endsequence
  sequence after_cmd_s;
    report_fire && (m_cr || m_ur || m_ns);
  endsequence
  sequence shown_s;
    report_valid && sense_asc == $past(asc_r) && sense_ascq == $past(ascq_r);
  endsequence
  standby_wake_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE24
    media_cmd_s |=> !standby)
    else $error("standby kept after media command");
  standby_enter_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE5
    standby_en_r && sby_expired && tick && !sby_load |=> standby)
    else $error("standby not entered after inactivity");
  test_stop_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE11
    test_dropped_s |=> !pend_r)
    else $error("false notice kept after test bit cleared");
  done_first_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE16
    after_cmd_s |-> cmd_done && !cmd_block)
    else $error("report before command completed");
  report_shown_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE7
    report_fire |=> shown_s)
    else $error("reported sense code differs from pending");
  rec_key_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE17
    report_fire && (m_cr || m_ur) |=> sense_key == `KEY_RECOVERED)
    else $error("recovered error key wrong");
  no_sense_key_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE18
    report_fire && m_ns |=> sense_key == `KEY_NO_SENSE)
    else $error("no sense key wrong");
  per_gate_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE16
    method == 4'(exc_pkg::M_COND_REC) && !per_bit |-> !report_fire)
    else $error("conditional report without post-error");
  temp_mask_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE6
    temp_over && !warn_en && !fail_ev && !test_ev && !pend_r |=> !pend_r)
    else $error("temperature warning while masked");
  temp_code_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE7
    temp_ev |=> pend_r && asc_r == `ASC_TEMP && ascq_r == `ASCQ_TEMP)
    else $error("temperature sense code wrong");
  single_report_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE21
    interval_r == 32'h0000_0000 && once_done_r |-> !report_fire)
    else $error("second report with zero interval");
  port_reject_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE2
    wr_port && wdata[31:16] != 16'h0000 |=> page_reject)
    else $error("nonzero timeout accepted");
  log_off_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE8
    exc_dis |-> !log_save_enable)
    else $error("log saving while exceptions disabled");
  read_idle_a: assert property (@(posedge clock) disable iff (!rst_n)
    !rd |=> rdata == 32'h0000_0000)
    else $error("read data outside read cycle");
endmodule
`default_nettype wire

// ### core/tick_gen.sv
// Purpose: one-cycle pulse every 100 ms
// Assumes: single clock
// Notes: period is a parameter so simulation can shorten it
`timescale 1ns/100ps
`default_nettype none
`include "exc_defines.svh"
module tick_gen #(
  parameter int CYCLES = `TICK_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  output logic tick
);
  initial
  begin
    if (CYCLES < 2)
      $error("tick_gen: CYCLES too small");
  end
  logic [31:0] cnt_r;
  wire last = (cnt_r == 32'(CYCLES - 1));
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      cnt_r <= 32'h0000_0000;
    else
      cnt_r <= last ? 32'h0000_0000 : cnt_r + 32'h0000_0001;
  end
  assign tick = last;
endmodule
`default_nettype wire

// ### core/tick_timer.sv
// Purpose: down counter in ticks, restartable, expiry level
// Assumes: tick is a one-cycle pulse
// Notes: load of zero expires at once
`timescale 1ns/100ps
`default_nettype none
module tick_timer #(
  parameter int W = 32
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic load,
  input wire logic [W-1:0] value,
  output logic expired
);
  initial
  begin
    if (W < 1)
      $error("tick_timer: bad width");
  end
  logic [W-1:0] cnt_r;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      cnt_r <= '0;
    else if (load)
      cnt_r <= value;
    else if (tick && cnt_r != '0)
      cnt_r <= cnt_r - 1'b1;
  end
  assign expired = (cnt_r == '0);
endmodule
`default_nettype wire

// ### pkg/exc_defines.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 25 MHz clock, 32-bit register port
// Notes: reserved bits read as zero
//
// Contract
// RULE1: port page reports protocol identifier one
// RULE2: initiator writes zero synchronous transfer timeout
// RULE3: initiator keeps idle bit and timer zero
// RULE4: standby bit enables standby timer use
// RULE5: standby timer counts 100 ms inactivity
// RULE6: warning enable gates temperature warnings
// RULE7: overtemperature reports sense 01h/0Bh/01h
// RULE8: exception disable stops all exception operations
// RULE9: exceptions enabled select reporting method
// RULE10: method ignored when disabled, warnings off
// RULE11: test bit issues false failure 5DFFh
// RULE12: background enable bit drives background functions
// RULE13: error logging and performance bits ignored
// RULE14: method zero silent, method one unsupported
// RULE15: method 2 unit attention, command not run
// RULE16: method 3 recovered error if post-error
// RULE17: method 4 recovered error always
// RULE18: method 5 no sense after completion
// RULE19: method 6 reports only on request sense
// RULE20: reports spaced by interval timer units
// RULE21: interval zero reports only once
// RULE22: report count limits, zero unlimited
// RULE23: methods seven to fifteen rejected illegal
// RULE24: commands restart standby count and wake; here every command restarts, only media commands wake
`ifndef EXC_DEFINES_SVH
`define EXC_DEFINES_SVH
`define ADDR_PORT_CTL 4'h0
`define ADDR_POWER_CTL 4'h1
`define ADDR_STANDBY_TMR 4'h2
`define ADDR_EXC_CTL 4'h3
`define ADDR_INTERVAL 4'h4
`define ADDR_REPORT_CNT 4'h5
`define ADDR_STATUS 4'h6
`define ADDR_SENSE 4'h7
`define PROTOCOL_ID 4'h1
`define BIT_STANDBY 0
`define BIT_IDLE 1
`define BIT_ERROR_LOG 0
`define BIT_TEST 2
`define BIT_EXC_DIS 3
`define BIT_WARN_EN 4
`define BIT_BG_EN 5
`define BIT_PERFORMANCE 7
`define FLD_METHOD_LSB 8
`define EXC_CTL_RESET 32'h0000_0008
`define KEY_NO_SENSE 4'h0
`define KEY_RECOVERED 4'h1
`define KEY_UNIT_ATTN 4'h6
`define ASC_TEMP 8'h0b
`define ASCQ_TEMP 8'h01
`define ASC_FAIL 8'h5d
`define ASCQ_TEST 8'hff
`define TICK_MS 100
`define CLOCK_KHZ 25000
`define TICK_CYCLES (`TICK_MS * `CLOCK_KHZ)
`endif

// ### pkg/exc_pkg.sv
// Purpose: types shared by the exception and standby logic
// Assumes: nothing
// Notes: method codes as carried on the page
package exc_pkg;
  typedef enum logic [3:0] {
    M_NONE = 4'h0, M_ASYNC = 4'h1, M_UNIT_ATTN = 4'h2, M_COND_REC = 4'h3,
    M_UNCOND_REC = 4'h4, M_NO_SENSE = 4'h5, M_ON_REQUEST = 4'h6
  } method_t;
  typedef enum {PW_ACTIVE, PW_STANDBY} power_t;
endpackage

// ### test/exception_report_standby_ctl_tb_top.sv
// Purpose: self-checking bench for page state, standby and reporting
// Assumes: tick shortened to 10 cycles
// Notes: reports counted by a monitor, not by the sequence
`timescale 1ns/100ps
`default_nettype none
`include "exc_defines.svh"
module exception_report_standby_ctl_tb_top;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr;
  logic [31:0] wdata;
  logic wr, rd, temp_over, fail_predict, per_bit;
  wire logic cmd_start, cmd_done, cmd_media, req_sense;
  logic [31:0] rdata, d;
  logic page_reject, cmd_block, report_valid, standby, background_on, log_save_enable, rej;
  logic [3:0] sense_key;
  logic [7:0] sense_asc, sense_ascq;
  logic [19:0] seen;
  int n_mismatch = 0, cmp_count = 0, n_rep = 0, n_blk = 0, cyc = 0, last = 0, gap = 0;

  exception_report_standby_ctl #(.TICK_CYCLES(10)) i_exception_report_standby_ctl (
    .clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .page_reject(page_reject), .temp_over(temp_over),
    .fail_predict(fail_predict), .per_bit(per_bit), .cmd_start(cmd_start),
    .cmd_done(cmd_done), .cmd_media(cmd_media), .req_sense(req_sense),
    .cmd_block(cmd_block), .report_valid(report_valid), .sense_key(sense_key),
    .sense_asc(sense_asc), .sense_ascq(sense_ascq), .standby(standby),
    .background_on(background_on), .log_save_enable(log_save_enable));
  initiator_model i_initiator_model (.clock(clock), .cmd_start(cmd_start),
    .cmd_done(cmd_done), .cmd_media(cmd_media), .req_sense(req_sense));

  always #20 clock = ~clock;

  // ------------------------------
  // monitor and hang limit
  // ------------------------------
  always @(posedge clock)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      n_mismatch++;
      results();
    end
    if (report_valid === 1'b1)
    begin
      if (n_rep > 0 && cyc - last < gap) gap = cyc - last;
      last = cyc;
      n_rep++;
      seen = {sense_key, sense_asc, sense_ascq};
    end
    if (cmd_start && cmd_block === 1'b1) n_blk++;
  end

  task results();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr_reg(input logic [3:0] a, input logic [31:0] v);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clock);
    wr <= 1'b0;
    #1 rej = page_reject;
  endtask
  task rd_reg(input logic [3:0] a);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  function automatic logic [31:0] exc(input logic [3:0] m, input logic [7:0] b);
    return {20'h0_0000, m, b};
  endfunction
  // three commands, optional poll, then did a report come and what
  task run(input logic [3:0] m, input logic [7:0] b, input bit p, input bit e,
           input logic [19:0] s);
    wr_reg(`ADDR_EXC_CTL, exc(m, b));
    n_rep = 0;
    n_blk = 0;
    repeat (3) i_initiator_model.command(1'b0);
    if (p) chk("silent before poll", 0, n_rep);
    if (p) i_initiator_model.poll();
    repeat (15) @(posedge clock);
    chk("reported", {31'h0, e}, {31'h0, n_rep != 0});
    if (e) chk("sense", {12'h000, s}, {12'h000, seen});
    chk("blocked", {31'h0, e && m == 4'h2}, {31'h0, n_blk != 0});
  endtask

  // ------------------------------
  // main sequence
  // ------------------------------
  initial
  begin
    void'($urandom(77204));
    addr <= 4'h0;
    wdata <= 32'h0000_0000;
    wr <= 1'b0;
    rd <= 1'b0;
    temp_over <= 1'b0;
    fail_predict <= 1'b0;
    per_bit <= 1'b0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    chk("log save at reset", 0, {31'h0, log_save_enable});
    rd_reg(`ADDR_PORT_CTL);
    chk("protocol id", 32'h0000_0001, d);
    for (int m = 7; m < 16; m++)
    begin
      wr_reg(`ADDR_EXC_CTL, exc(m[3:0], 8'h10));
      chk("reserved method", 1, {31'h0, rej});
    end
    rd_reg(`ADDR_EXC_CTL);
    chk("exc ctl kept", `EXC_CTL_RESET, d);
    wr_reg(`ADDR_PORT_CTL, 32'h0001_0000);
    chk("timeout nonzero", 1, {31'h0, rej});
    wr_reg(`ADDR_PORT_CTL, 32'h0000_0000);
    chk("timeout zero", 0, {31'h0, rej});
    wr_reg(`ADDR_POWER_CTL, 32'h0000_0002);
    chk("idle bit", 1, {31'h0, rej});
    repeat (4)
    begin
      wr_reg(4'h8 + 4'($urandom_range(0, 7)), $urandom);
      rd_reg(4'h8 + 4'($urandom_range(0, 7)));
      chk("unmapped read", 0, d);
    end
    // standby after two ticks idle, restarted by commands
    wr_reg(`ADDR_STANDBY_TMR, 32'h0000_0002);
    wr_reg(`ADDR_POWER_CTL, 32'h0000_0001);
    repeat (5) @(posedge clock);
    chk("standby early", 0, {31'h0, standby});
    repeat (6) i_initiator_model.command(1'b0);
    chk("standby busy", 0, {31'h0, standby});
    repeat (40) @(posedge clock);
    rd_reg(`ADDR_STATUS);
    chk("standby entered", 1, {31'h0, d[0]});
    i_initiator_model.command(1'b1);
    #1 chk("standby left", 0, {31'h0, standby});
    wr_reg(`ADDR_POWER_CTL, 32'h0000_0000);
    repeat (60) @(posedge clock);
    chk("standby off", 0, {31'h0, standby});
    // reporting methods against a standing overtemperature
    temp_over <= 1'b1;
    wr_reg(`ADDR_INTERVAL, 32'h0000_0001);
    run(4'h2, 8'h08, 0, 0, 20'h0_0000);
    chk("log save", 0, {31'h0, log_save_enable});
    run(4'h2, 8'h00, 0, 0, 20'h0_0000);
    run(4'h0, 8'h10, 0, 0, 20'h0_0000);
    run(4'h1, 8'h10, 0, 0, 20'h0_0000);
    chk("log save", 1, {31'h0, log_save_enable});
    run(4'h2, 8'h10, 0, 1, {`KEY_UNIT_ATTN, `ASC_TEMP, `ASCQ_TEMP});
    run(4'h3, 8'h10, 0, 0, 20'h0_0000);
    per_bit <= 1'b1;
    run(4'h3, 8'h10, 0, 1, {`KEY_RECOVERED, `ASC_TEMP, `ASCQ_TEMP});
    per_bit <= 1'b0;
    run(4'h4, 8'hb1, 0, 1, {`KEY_RECOVERED, `ASC_TEMP, `ASCQ_TEMP});
    chk("background", 1, {31'h0, background_on});
    run(4'h5, 8'h10, 0, 1, {`KEY_NO_SENSE, `ASC_TEMP, `ASCQ_TEMP});
    run(4'h6, 8'h10, 1, 1, {`KEY_NO_SENSE, `ASC_TEMP, `ASCQ_TEMP});
    chk("background off", 0, {31'h0, background_on});
    // spacing, count limit and single report
    wr_reg(`ADDR_INTERVAL, 32'h0000_0003);
    wr_reg(`ADDR_EXC_CTL, exc(4'h4, 8'h10));
    n_rep = 0;
    gap = 1000;
    repeat (14) i_initiator_model.command(1'b0);
    chk("spaced", 1, {31'h0, gap >= 20 && n_rep >= 2});
    wr_reg(`ADDR_INTERVAL, 32'h0000_0001);
    wr_reg(`ADDR_REPORT_CNT, 32'h0000_0002);
    n_rep = 0;
    repeat (8)
    begin
      i_initiator_model.command(1'b0);
      repeat (15) @(posedge clock);
    end
    chk("count limit", 2, n_rep);
    wr_reg(`ADDR_INTERVAL, 32'h0000_0000);
    wr_reg(`ADDR_REPORT_CNT, 32'h0000_0000);
    n_rep = 0;
    repeat (5) i_initiator_model.command(1'b0);
    repeat (30) @(posedge clock);
    chk("single report", 1, n_rep);
    temp_over <= 1'b0;
    wr_reg(`ADDR_INTERVAL, 32'h0000_0001);
    run(4'h5, 8'h14, 0, 1, {`KEY_NO_SENSE, `ASC_FAIL, `ASCQ_TEST});
    run(4'h5, 8'h10, 0, 0, 20'h0_0000);
    fail_predict <= 1'b1;
    run(4'h4, 8'h00, 0, 1, {`KEY_RECOVERED, `ASC_FAIL, 8'h00});
    fail_predict <= 1'b0;
    results();
  end
endmodule
`default_nettype wire

// ### test/initiator_model.sv
// Purpose: initiator side that issues commands and sense polls
// Assumes: same clock as the target logic
// Notes: busy time per command is random
`timescale 1ns/100ps
`default_nettype none
module initiator_model (
  input wire logic clock,
  output logic cmd_start,
  output logic cmd_done,
  output logic cmd_media,
  output logic req_sense
);
  initial
  begin
    cmd_start = 1'b0;
    cmd_done = 1'b0;
    cmd_media = 1'b0;
    req_sense = 1'b0;
  end
  // media level held across the whole command
  task automatic command(input logic media);
    @(posedge clock);
    cmd_start <= 1'b1;
    cmd_media <= media;
    @(posedge clock);
    cmd_start <= 1'b0;
    repeat ($urandom_range(2, 5)) @(posedge clock);
    cmd_done <= 1'b1;
    @(posedge clock);
    cmd_done <= 1'b0;
    cmd_media <= 1'b0;
  endtask
  // unsolicited sense request, the only way method six reports
  task automatic poll();
    @(posedge clock);
    req_sense <= 1'b1;
    @(posedge clock);
    req_sense <= 1'b0;
  endtask
endmodule
`default_nettype wire
